// file: dsl_pkg.sv
// Constants and types for the DDR strobe read polarity and leveling block
package dsl_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int STB_PERIOD_NS = 160;
  localparam int TM_W = 8;
  // Least time, rounded up to whole cycles
  localparam logic [TM_W-1:0] STB_HALF_CYC =
    TM_W'((STB_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
  localparam logic [TM_W-1:0] TM_ONE = 8'h01;
  localparam logic [TM_W-1:0] TM_ZERO = 8'h00;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DLL_CODE_W = 7;
  localparam int WL_SET_W = 8;
  localparam int WL_STEP_W = 7;
  localparam int RCNT_W = 16;
  localparam int ADDR_W = 8;

  // ----------------------------------------
  // APB register map
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WLVL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RCNT = 8'h0c;
  localparam int CTRL_X2_BIT = 0;
  localparam logic CTRL_X2_RST = 1'b1;
  localparam logic [WL_SET_W-1:0] WLVL_RST = 8'h00;
  localparam int STAT_POL_BIT = 0;
  localparam int STAT_RBUSY_BIT = 1;
  localparam int STAT_WBUSY_BIT = 2;
  localparam int STAT_DLL_LSB = 8;
  localparam int STAT_WL_LSB = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic invert;
    logic [WL_STEP_W-1:0] step;
  } dsl_wlvl_s;

  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_PRE, R_BURST} dsl_rd_e;
  typedef enum logic [2:0] {W_IDLE, W_DELAY, W_PRE, W_BURST, W_POST} dsl_wr_e;

endpackage

// file: dsl_top.sv
// DDR strobe read polarity, read capture gearing and write leveling strobe
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module dsl_top import dsl_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int BURST_BEATS = 8,
  parameter int DLY_TAPS = 8
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // DLL calibration
  input wire logic [DLL_CODE_W-1:0] DLL_CODE,
  // Strobe pin
  input wire logic DQS_I,
  output logic DQS_O,
  output logic DQS_OE_N,
  // Data pins
  input wire logic [DQ_W-1:0] DQ_I,
  output logic [DQ_W-1:0] DQ_O,
  output logic DQ_OE_N,
  // Fabric read side
  input wire logic RD_REQ,
  output logic [4*DQ_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic RD_BUSY,
  output logic READ_SYNC_CLOCK_POLARITY,
  output logic READ_STAGE_TRANSFER_LATCH,
  // Fabric write side
  input wire logic WR_REQ,
  input wire logic [BURST_BEATS*DQ_W-1:0] WR_DATA,
  output logic WR_BUSY
);

  // ----------------------------------------
  // Local sizes and state
  // ----------------------------------------
  localparam int TAP_W = $clog2(DLY_TAPS);
  localparam int WORD_W = 4 * DQ_W;
  localparam int PAIR_W = 2 * DQ_W;
  localparam int WBURST_W = BURST_BEATS * DQ_W;
  localparam int BEAT_W = $clog2(BURST_BEATS + 1);
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(BURST_BEATS);
  localparam logic [BEAT_W-1:0] BEAT_ONE = BEAT_W'(1);

  typedef struct packed {
    logic [1:0] dqs_sync;
    logic [1:0][DQ_W-1:0] dq_sync;
    logic [DLY_TAPS-1:0] dly_line;
    logic dly_prev;
    logic phase;
    dsl_rd_e rd_st;
    logic pol;
    logic [BEAT_W-1:0] rbeat;
    logic pair_odd;
    logic [DQ_W-1:0] set1_rise;
    logic [DQ_W-1:0] set1_fall;
    logic [PAIR_W-1:0] set2;
    logic [WORD_W-1:0] pend;
    logic pend_v;
    logic [WORD_W-1:0] rd_data;
    logic rd_valid;
    logic latch;
    logic rd_busy;
    dsl_wr_e wr_st;
    logic [TM_W-1:0] tm;
    logic [BEAT_W-1:0] wbeat;
    logic [WBURST_W-1:0] wshift;
    logic dqs_o;
    logic dqs_oe_n;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe_n;
    logic wr_busy;
    logic x2;
    dsl_wlvl_s wl_req;
    dsl_wlvl_s wl_act;
    logic [RCNT_W-1:0] rcnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsl_state_s;

  dsl_state_s s_ff;
  dsl_state_s nxt_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic tap;
    logic rise;
    logic fall;
    logic [DQ_W-1:0] dq;
    logic [PAIR_W-1:0] pair;
    tap = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    dq = '0;
    pair = '0;
    nxt_s = s_ff;
    // Pins pass two flops before any logic looks at them
    nxt_s.dqs_sync = {s_ff.dqs_sync[0], DQS_I};
    nxt_s.dq_sync = {s_ff.dq_sync[0], DQ_I};
    dq = s_ff.dq_sync[1];

    nxt_s.dly_line = {s_ff.dly_line[DLY_TAPS-2:0], s_ff.dqs_sync[1]};
    tap = s_ff.dly_line[DLL_CODE[TAP_W-1:0]];
    rise = tap && !s_ff.dly_prev;
    fall = !tap && s_ff.dly_prev;
    nxt_s.dly_prev = tap;
    nxt_s.phase = !s_ff.phase;

    // APB: answer prepared in setup, shown in access phase
    nxt_s.pready = 1'b0;
    nxt_s.pslverr = 1'b0;
    if (PSEL && !PENABLE && !s_ff.pready) begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = '0;
      case (PADDR)
        ADDR_CTRL: nxt_s.prdata[CTRL_X2_BIT] = s_ff.x2;
        ADDR_WLVL: nxt_s.prdata[WL_SET_W-1:0] = s_ff.wl_req;
        ADDR_STAT: begin
          nxt_s.prdata[STAT_POL_BIT] = s_ff.pol;
          nxt_s.prdata[STAT_RBUSY_BIT] = s_ff.rd_busy;
          nxt_s.prdata[STAT_WBUSY_BIT] = s_ff.wr_busy;
          nxt_s.prdata[STAT_DLL_LSB +: DLL_CODE_W] = DLL_CODE;
          nxt_s.prdata[STAT_WL_LSB +: WL_SET_W] = s_ff.wl_act;
        end
        ADDR_RCNT: nxt_s.prdata[RCNT_W-1:0] = s_ff.rcnt;
        default: nxt_s.pslverr = 1'b1;
      endcase
    end
    if (PSEL && PENABLE && s_ff.pready && PWRITE && !s_ff.pslverr) begin
      case (PADDR)
        ADDR_CTRL: nxt_s.x2 = PWDATA[CTRL_X2_BIT];
        ADDR_WLVL: nxt_s.wl_req = PWDATA[WL_SET_W-1:0];
        default: nxt_s.x2 = s_ff.x2;
      endcase
    end

    // sync stage fires only on the chosen phase
    nxt_s.rd_valid = 1'b0;
    nxt_s.latch = 1'b0;
    if (s_ff.pend_v && (s_ff.phase == s_ff.pol)) begin
      nxt_s.rd_data = s_ff.pend;
      nxt_s.rd_valid = 1'b1;
      nxt_s.pend_v = 1'b0;
    end

    // Read capture
    case (s_ff.rd_st)
      R_IDLE: begin
        if (RD_REQ && (s_ff.wr_st == W_IDLE)) begin
          nxt_s.rd_st = R_WAIT;
        end
      end
      R_WAIT: begin
        // strobe rests high, low marks preamble
        if (!tap) begin
          nxt_s.rd_st = R_PRE;
        end
      end
      R_PRE: begin
        if (rise) begin
          nxt_s.pol = s_ff.phase;
          nxt_s.set1_rise = dq;
          nxt_s.rbeat = BEAT_ONE;
          nxt_s.pair_odd = 1'b0;
          nxt_s.rd_st = R_BURST;
        end
      end
      R_BURST: begin
        if (rise) begin
          nxt_s.set1_rise = dq;
          nxt_s.rbeat = s_ff.rbeat + BEAT_ONE;
        end
        if (fall) begin
          nxt_s.set1_fall = dq;
          nxt_s.rbeat = s_ff.rbeat + BEAT_ONE;
          pair = {dq, s_ff.set1_rise};
          if (!s_ff.x2) begin
            nxt_s.pend = WORD_W'(pair);
            nxt_s.pend_v = 1'b1;
          end else if (!s_ff.pair_odd) begin
            nxt_s.set2 = pair;
            nxt_s.latch = 1'b1;
            nxt_s.pair_odd = 1'b1;
          end else begin
            nxt_s.pend = {pair, s_ff.set2};
            nxt_s.pend_v = 1'b1;
            nxt_s.pair_odd = 1'b0;
          end
          if ((s_ff.rbeat + BEAT_ONE) == BEAT_LAST) begin
            nxt_s.rd_st = R_IDLE;
            nxt_s.rcnt = s_ff.rcnt + RCNT_W'(1);
          end
        end
      end
      default: nxt_s.rd_st = R_IDLE;
    endcase

    // Write strobe and data
    case (s_ff.wr_st)
      W_IDLE: begin
        // new setting applied only between bursts
        nxt_s.wl_act = s_ff.wl_req;
        if (WR_REQ && (nxt_s.rd_st == R_IDLE)) begin
          nxt_s.wshift = WR_DATA;
          nxt_s.tm = TM_W'(s_ff.wl_req.step) + (s_ff.wl_req.invert ? STB_HALF_CYC : TM_ZERO);
          nxt_s.wr_st = W_DELAY;
        end
      end
      W_DELAY: begin
        if (s_ff.tm == TM_ZERO) begin
          nxt_s.dqs_oe_n = 1'b0;
          nxt_s.dqs_o = 1'b0;
          nxt_s.tm = STB_HALF_CYC + STB_HALF_CYC - TM_ONE;
          nxt_s.wr_st = W_PRE;
        end else begin
          nxt_s.tm = s_ff.tm - TM_ONE;
        end
      end
      W_PRE: begin
        if (s_ff.tm == TM_ZERO) begin
          // write gearing, one beat per half period
          nxt_s.dqs_o = 1'b1;
          nxt_s.dq_oe_n = 1'b0;
          nxt_s.dq_o = s_ff.wshift[DQ_W-1:0];
          nxt_s.wshift = s_ff.wshift >> DQ_W;
          nxt_s.wbeat = BEAT_ONE;
          nxt_s.tm = STB_HALF_CYC - TM_ONE;
          nxt_s.wr_st = W_BURST;
        end else begin
          nxt_s.tm = s_ff.tm - TM_ONE;
        end
      end
      W_BURST: begin
        if (s_ff.tm != TM_ZERO) begin
          nxt_s.tm = s_ff.tm - TM_ONE;
        end else if (s_ff.wbeat == BEAT_LAST) begin
          nxt_s.dqs_o = 1'b0;
          nxt_s.dq_oe_n = 1'b1;
          nxt_s.tm = STB_HALF_CYC - TM_ONE;
          nxt_s.wr_st = W_POST;
        end else begin
          nxt_s.dqs_o = !s_ff.dqs_o;
          nxt_s.dq_o = s_ff.wshift[DQ_W-1:0];
          nxt_s.wshift = s_ff.wshift >> DQ_W;
          nxt_s.wbeat = s_ff.wbeat + BEAT_ONE;
          nxt_s.tm = STB_HALF_CYC - TM_ONE;
        end
      end
      W_POST: begin
        if (s_ff.tm == TM_ZERO) begin
          nxt_s.dqs_oe_n = 1'b1;
          nxt_s.wr_st = W_IDLE;
        end else begin
          nxt_s.tm = s_ff.tm - TM_ONE;
        end
      end
      default: nxt_s.wr_st = W_IDLE;
    endcase
    nxt_s.rd_busy = (nxt_s.rd_st != R_IDLE);
    nxt_s.wr_busy = (nxt_s.wr_st != W_IDLE);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable low freezes everything, synchronisers included
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_ff <= '0;
      s_ff.dqs_sync <= '1;
      s_ff.dly_line <= '1;
      s_ff.dqs_oe_n <= 1'b1;
      s_ff.dq_oe_n <= 1'b1;
      s_ff.x2 <= CTRL_X2_RST;
      s_ff.wl_req <= WLVL_RST;
      s_ff.wl_act <= WLVL_RST;
    end else if (CE) begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA = s_ff.prdata;
  assign PREADY = s_ff.pready;
  assign PSLVERR = s_ff.pslverr;
  assign DQS_O = s_ff.dqs_o;
  assign DQS_OE_N = s_ff.dqs_oe_n;
  assign DQ_O = s_ff.dq_o;
  assign DQ_OE_N = s_ff.dq_oe_n;
  assign RD_DATA = s_ff.rd_data;
  assign RD_VALID = s_ff.rd_valid;
  assign RD_BUSY = s_ff.rd_busy;
  assign READ_SYNC_CLOCK_POLARITY = s_ff.pol;
  assign READ_STAGE_TRANSFER_LATCH = s_ff.latch;
  assign WR_BUSY = s_ff.wr_busy;
endmodule
`default_nettype wire

// file: dsl_monitor.sv
// Port checker for the strobe polarity and leveling block
`timescale 1ns/100ps
`default_nettype none
module dsl_monitor import dsl_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Read and write sides
  input wire logic RD_BUSY,
  input wire logic RD_VALID,
  input wire logic READ_SYNC_CLOCK_POLARITY,
  input wire logic READ_STAGE_TRANSFER_LATCH,
  input wire logic DQS_O,
  input wire logic DQS_OE_N,
  input wire logic DQ_OE_N
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence pre_s;
    (!DQS_O && DQ_OE_N) [*8] ##1 DQS_O;
  endsequence
  // Strobe must stay driven low until the memory has seen the last beat
  sequence post_s;
    (!DQS_O && !DQS_OE_N) [*4] ##1 DQS_OE_N;
  endsequence
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("long ready");
  a_unmapped_err: assert property (PSEL && !PENABLE && (PADDR > 8'h0c || PADDR[1:0] != 2'h0) |=> PSLVERR)
    else $error("no refusal");
  a_pol_read_only: assert property ($changed(READ_SYNC_CLOCK_POLARITY) |-> RD_BUSY)
    else $error("polarity moved");
  a_latch_pulse: assert property (READ_STAGE_TRANSFER_LATCH |=> !READ_STAGE_TRANSFER_LATCH)
    else $error("long latch");
  a_valid_pulse: assert property (RD_VALID |=> !RD_VALID) else $error("long valid");
  a_data_in_strobe: assert property (!DQ_OE_N |-> !DQS_OE_N) else $error("data without strobe");
  a_write_preamble: assert property ($fell(DQS_OE_N) |-> pre_s) else $error("bad preamble");
  a_write_postamble: assert property ($rose(DQ_OE_N) |-> post_s) else $error("bad postamble");
endmodule
`default_nettype wire

// file: dsl_mem_model.sv
// Memory-side model driving strobe and data for reads
`timescale 1ns/100ps
`default_nettype none
module dsl_mem_model (
  // Toward the block
  output logic dqs,
  output logic [7:0] dq
);
  // ----------------
  // Read burst
  // ----------------
  initial begin
    dqs = 1'b1;
    dq = 8'ha5;
  end
  // Strobe clock stands still between bursts; released data shows the last beat again
  task automatic burst(input logic [63:0] d, input int skew);
    int i;
    #(skew);
    dqs = 1'b1;
    dq = ~dq;
    #160;
    dqs = 1'b0;
    #160;
    for (i = 0; i < 8; i++) begin
      dqs = ~dqs;
      dq = d[i*8 +: 8];
      #80;
    end
    dq = ~dq;
    #80;
    dqs = 1'b1;
    dq = ~dq;
  endtask
endmodule
`default_nettype wire

// file: dsl_top_bench.sv
// Self-checking bench for the strobe polarity and leveling block
`timescale 1ns/100ps
`default_nettype none
module dsl_top_bench import dsl_pkg::*; ;
  localparam logic [63:0] PAT = 64'h8877665544332211;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
  logic [7:0] paddr = 8'h00, dq_o, mem_dq, dq_i;
  logic [31:0] pwdata = 32'h0, prdata, rd_data, rmask = 32'hffffffff;
  logic [6:0] dll_code = 7'h02;
  logic [63:0] wr_data = 64'h0;
  logic pready, pslverr, dqs_o, dqs_oe_n, dq_oe_n, rd_valid, rd_busy, pol, lat, wr_busy, mem_dqs, dqs_i;
  int fail_count = 0, checks = 0, nlat = 0, i;
  logic [31:0] words[$];
  // ----------------
  // Pins and instances
  // ----------------
  assign dqs_i = dqs_oe_n ? mem_dqs : dqs_o;
  assign dq_i = dq_oe_n ? mem_dq : dq_o;
  dsl_mem_model i_mem (.dqs(mem_dqs), .dq(mem_dq));
  dsl_top i_dut (.CLK(clk), .SYS_RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DLL_CODE(dll_code), .DQS_I(dqs_i), .DQS_O(dqs_o), .DQS_OE_N(dqs_oe_n), .DQ_I(dq_i), .DQ_O(dq_o),
    .DQ_OE_N(dq_oe_n), .RD_REQ(rd_req), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_BUSY(rd_busy),
    .READ_SYNC_CLOCK_POLARITY(pol), .READ_STAGE_TRANSFER_LATCH(lat), .WR_REQ(wr_req),
    .WR_DATA(wr_data), .WR_BUSY(wr_busy));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    if (rd_valid === 1'b1) words.push_back(rd_data);
    if (lat === 1'b1) nlat++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // Write data doubles as the expected value on reads
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe, input string m);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    if (!w) chk(prdata & rmask, d, m);
    chk(pslverr, xe, m);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic do_read(input int skew);
    words = {};
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    i_mem.burst(PAT, skew);
    while (rd_busy !== 1'b0) begin
      @(posedge clk);
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic do_write(input logic [63:0] d, input int lat);
    int n, k;
    logic s;
    s = 1'b0;
    n = 0;
    @(posedge clk);
    wr_req <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_req <= 1'b0;
    while (dqs_oe_n !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk(n, lat, "strobe delay");
    for (k = 0; k < 8; k++) begin
      n = 0;
      while (dqs_o === s) begin
        @(posedge clk);
        n++;
      end
      s = dqs_o;
      chk(n, k ? 4 : 8, "beat spacing");
      chk(dq_o, d[k*8 +: 8], "beat data");
    end
    while (wr_busy !== 1'b0) begin
      @(posedge clk);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h1, 1'b0, "ctrl reset");
    apb(1'b0, ADDR_WLVL, 32'h0, 1'b0, "wlvl reset");
    apb(1'b0, ADDR_STAT, 32'h200, 1'b0, "stat idle");
    apb(1'b1, 8'h10, 32'hffffffff, 1'b1, "unmapped write");
    apb(1'b0, 8'h10, 32'h0, 1'b1, "unmapped read");
    $display("register test done");
    do_read(3);
    chk(words.size(), 2, "x2 count");
    chk(words[0], PAT[31:0], "x2 word");
    chk(words[1], PAT[63:32], "x2 word");
    chk(nlat, 2, "latch pulses");
    apb(1'b0, ADDR_RCNT, 32'h1, 1'b0, "read count");
    $display("x2 read test done");
    apb(1'b1, ADDR_CTRL, 32'h0, 1'b0, "x1 mode");
    dll_code <= 7'h01;
    do_read(13);
    chk(words.size(), 4, "x1 count");
    for (i = 0; i < 4; i++) chk(words[i], {16'h0, PAT[i*16 +: 16]}, "x1 word");
    apb(1'b0, ADDR_RCNT, 32'h2, 1'b0, "read count");
    $display("x1 read test done");
    apb(1'b1, ADDR_WLVL, 32'h03, 1'b0, "wlvl set");
    fork
      do_write(PAT, 5);
      begin
        repeat (12) @(posedge clk);
        apb(1'b1, ADDR_WLVL, 32'h83, 1'b0, "wlvl in burst");
        // Polarity bit holds the clock phase caught at the last read, so it is masked
        rmask = 32'hfffffffe;
        apb(1'b0, ADDR_STAT, 32'h00030104, 1'b0, "setting held in burst");
        rmask = 32'hffffffff;
      end
    join
    apb(1'b0, ADDR_WLVL, 32'h83, 1'b0, "wlvl readback");
    do_write(~PAT, 9);
    $display("write test done");
    final_report;
  end
  initial begin
    #50000;
    fail_count++;
    final_report;
  end
endmodule
bind dsl_top dsl_monitor i_mon (.CLK, .SYS_RST, .PSEL, .PENABLE, .PADDR, .PREADY, .PSLVERR, .RD_BUSY,
  .RD_VALID, .READ_SYNC_CLOCK_POLARITY, .READ_STAGE_TRANSFER_LATCH, .DQS_O, .DQS_OE_N, .DQ_OE_N);
`default_nettype wire
